// >>> hdl/bru_cfg.svh
// Constants for the byte rotate unit: widths, bit positions and reset values
`ifndef BRU_CFG_SVH
`define BRU_CFG_SVH
// Data width of memory byte and accumulator
`define BRU_DATA_W 8
// Top and lowest bit positions of the byte
`define BRU_TOP_BIT 7
`define BRU_LOW_BIT 0
// Reset values of the result byte and carry
`define BRU_RESULT_RST 8'h00
`define BRU_CARRY_RST 1'b0
// Execution latency in clock cycles from request to result
`define BRU_LATENCY 1
`endif

// >>> hdl/bru_pkg.sv
// Package for the byte rotate unit: operation codes and carrier structs
package bru_pkg;
    // Decoded rotate operation
    typedef enum logic [2:0] {
        BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR,
        BRU_OP_ROTATE_LEFT_THROUGH_CARRY,
        BRU_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR,
        BRU_OP_ROTATE_RIGHT_IN_MEMORY,
        BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR,
        BRU_OP_ROTATE_RIGHT_THROUGH_CARRY,
        BRU_OP_ROTATE_LEFT_IN_MEMORY,
        BRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR
    } bru_op_t;

    // Request from the core's decoder
    typedef struct packed {
        logic       valid;  // One-cycle execute strobe
        bru_op_t    op;     // Which rotate
        logic [7:0] mem;    // Memory operand byte
        logic       carry;  // Current carry flag
    } bru_req_t;

    // Combinational outcome of one rotate
    typedef struct packed {
        logic [7:0] result;    // Rotated byte
        logic       to_acc;    // 1: accumulator, 0: memory
        logic       carry;     // Carry after the operation
        logic       carry_we;  // Carry is written
    } bru_res_t;
endpackage : bru_pkg

// >>> hdl/bru_rotate_core.sv
// Combinational rotate core: forms result, destination and carry
`timescale 1ns/100ps
`include "bru_cfg.svh"
module bru_rotate_core (
    // Request in
    input  wire bru_pkg::bru_req_t req,
    // Outcome out
    output bru_pkg::bru_res_t      res
);
    // Decode shift direction, carry usage and destination
    always_comb begin
        res = '0;
        case (req.op)
            bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
                res.result = {req.mem[`BRU_TOP_BIT-1:0], req.mem[`BRU_TOP_BIT]};
                res.to_acc = 1'b1;
                res.carry  = req.carry;
            end
            // Plain left rotate kept in memory
            bru_pkg::BRU_OP_ROTATE_LEFT_IN_MEMORY: begin
                res.result = {req.mem[`BRU_TOP_BIT-1:0], req.mem[`BRU_TOP_BIT]};
                res.carry  = req.carry;
            end
            bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                res.result   = {req.mem[`BRU_TOP_BIT-1:0], req.carry};
                res.carry    = req.mem[`BRU_TOP_BIT];
                res.carry_we = 1'b1;
            end
            bru_pkg::BRU_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
                res.result   = {req.mem[`BRU_TOP_BIT-1:0], req.carry};
                res.to_acc   = 1'b1;
                res.carry    = req.mem[`BRU_TOP_BIT];
                res.carry_we = 1'b1;
            end
            bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY: begin
                res.result = {req.mem[`BRU_LOW_BIT], req.mem[`BRU_TOP_BIT:1]};
                res.carry  = req.carry;
            end
            bru_pkg::BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
                res.result = {req.mem[`BRU_LOW_BIT], req.mem[`BRU_TOP_BIT:1]};
                res.to_acc = 1'b1;
                res.carry  = req.carry;
            end
            bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                res.result   = {req.carry, req.mem[`BRU_TOP_BIT:1]};
                res.carry    = req.mem[`BRU_LOW_BIT];
                res.carry_we = 1'b1;
            end
            // Right through carry, accumulator target
            bru_pkg::BRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR: begin
                res.result   = {req.carry, req.mem[`BRU_TOP_BIT:1]};
                res.to_acc   = 1'b1;
                res.carry    = req.mem[`BRU_LOW_BIT];
                res.carry_we = 1'b1;
            end
            // Unknown code: keep carry, write nothing useful
            default: begin
                res.carry = req.carry;
            end
        endcase
    end
endmodule : bru_rotate_core

// >>> hdl/bru_byte_rotate_unit.sv
// Top of the byte rotate unit: registered rotate datapath with checks
// Overview of operation
// - left rotate to accumulator, flags untouched
// - left through carry, result to memory
// - left through carry, result to accumulator
// - right rotate in memory, flags untouched
// - right rotate to accumulator, flags untouched
// - right through carry, result to memory
`timescale 1ns/100ps
`include "bru_cfg.svh"
module bru_byte_rotate_unit (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // Request from decoder
    input  wire bru_pkg::bru_req_t req,
    // Result to writeback
    output logic                   done_q,
    output logic [7:0]             result_q,
    output logic                   acc_we_q,
    output logic                   mem_we_q,
    output logic                   carry_q
);
    // Outcome of the combinational core; settles within the request cycle
    bru_pkg::bru_res_t res;

    // Pure decode and wiring: no state lives in the core, so every rotate
    // reaches the flops below in the same cycle that the decoder offers it
    bru_rotate_core u_core (
        .req (req),
        .res (res)
    );

    // one-step completion strobe
    // Done is the request strobe delayed by one edge; there is no stall
    // path, so a held strobe yields one done per cycle, back to back
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Reset drops a request taken in the same cycle
            done_q <= 1'b0;
        end else begin
            // One done for every taken request
            done_q <= req.valid;
        end
    end

    // result byte and destination strobes together
    // Both strobes come from one request, so exactly one of them is high
    // in the cycle after a request and neither is high when idle
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Cleared byte and no writeback after reset
            result_q <= `BRU_RESULT_RST;
            acc_we_q <= 1'b0;
            mem_we_q <= 1'b0;
        end else begin
            // Accumulator target: memory byte is left alone
            acc_we_q <= req.valid & res.to_acc;
            // Memory target: accumulator is left alone
            mem_we_q <= req.valid & ~res.to_acc;
            // Hold the last result when idle, so writeback sees a stable byte
            if (req.valid) begin
                result_q <= res.result;
            end
        end
    end

    // carry kept as a flag: carry ops load it, other cycles copy the supplied flag
    // Carry is registered here to reach writeback with the result; the next rotate takes req.carry
    // Limitation: with no carry op the flop mirrors the supplied flag one
    // cycle late, so the core stays the owner of the carry state
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Carry cleared by reset
            carry_q <= `BRU_CARRY_RST;
        end else if (req.valid && res.carry_we) begin
            carry_q <= res.carry;
        end else begin
            // Plain rotates and idle cycles pass the supplied flag
            carry_q <= req.carry;
        end
    end

    // Checks, one clock domain; reset cancels any attempt in flight except a_reset_clear
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Each rotate is checked against its own bit formula one cycle later,
    // with the operands taken from the cycle in which it was requested

    a_left_acc_wrap: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR |=>
        result_q == {$past(req.mem[6:0]), $past(req.mem[7])}
        && acc_we_q && !mem_we_q
        && carry_q == $past(req.carry))
        else $error("left rotate to accumulator wrong");

    a_left_carry_mem: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY |=>
        result_q == {$past(req.mem[6:0]), $past(req.carry)}
        && mem_we_q && !acc_we_q
        && carry_q == $past(req.mem[7]))
        else $error("left rotate through carry wrong");

    a_left_carry_acc: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR |=>
        result_q == {$past(req.mem[6:0]), $past(req.carry)}
        && acc_we_q && !mem_we_q
        && carry_q == $past(req.mem[7]))
        else $error("left carry to accumulator wrong");

    a_right_mem_wrap: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY |=>
        result_q == {$past(req.mem[0]), $past(req.mem[7:1])}
        && mem_we_q && !acc_we_q
        && carry_q == $past(req.carry))
        else $error("right rotate in memory wrong");

    a_right_acc_wrap: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR |=>
        result_q == {$past(req.mem[0]), $past(req.mem[7:1])}
        && acc_we_q && !mem_we_q
        && carry_q == $past(req.carry))
        else $error("right rotate to accumulator wrong");

    a_right_carry_mem: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY |=>
        result_q == {$past(req.carry), $past(req.mem[7:1])}
        && mem_we_q && !acc_we_q
        && carry_q == $past(req.mem[0]))
        else $error("right rotate through carry wrong");

    // Plain left rotate kept in memory, carry untouched
    a_left_mem_wrap: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_LEFT_IN_MEMORY |=>
        result_q == {$past(req.mem[6:0]), $past(req.mem[7])}
        && mem_we_q && !acc_we_q
        && carry_q == $past(req.carry))
        else $error("left rotate in memory wrong");

    // Nine-bit right rotate with the accumulator as target
    a_right_carry_acc: assert property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR |=>
        result_q == {$past(req.carry), $past(req.mem[7:1])}
        && acc_we_q && !mem_we_q
        && carry_q == $past(req.mem[0]))
        else $error("right carry to accumulator wrong");

    a_done_pairs: assert property (
        done_q == (acc_we_q || mem_we_q) && !(acc_we_q && mem_we_q))
        else $error("destination strobe not paired with done");

    // result and carry in one step
    a_one_step: assert property (
        req.valid |=> done_q
        && result_q == $past(res.result)
        && carry_q == $past(res.carry))
        else $error("rotate did not finish in one step");

    a_done_source: assert property (
        done_q |-> $past(req.valid))
        else $error("done raised with no request");

    // Idle cycles raise nothing and keep the byte
    a_idle_quiet: assert property (
        !req.valid |=> !done_q && !acc_we_q && !mem_we_q && $stable(result_q))
        else $error("output moved with no request");

    // Idle cycles pass the supplied carry through
    a_idle_carry: assert property (
        !req.valid |=> carry_q == $past(req.carry))
        else $error("carry changed with no request");

    a_plain_keep_carry: assert property (
        req.valid && req.op inside {bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR,
                                    bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY,
                                    bru_pkg::BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR,
                                    bru_pkg::BRU_OP_ROTATE_LEFT_IN_MEMORY}
        |=> carry_q == $past(req.carry))
        else $error("plain rotate changed the carry");

    // accumulator written by accumulator ops only
    a_acc_dest_ops: assert property (
        acc_we_q |-> $past(req.op) inside {bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR,
                     bru_pkg::BRU_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR,
                     bru_pkg::BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR,
                     bru_pkg::BRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR})
        else $error("accumulator written by a memory rotate");

    // memory written by memory ops only
    a_mem_dest_ops: assert property (
        mem_we_q |-> $past(req.op) inside {bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY,
                     bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY,
                     bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY,
                     bru_pkg::BRU_OP_ROTATE_LEFT_IN_MEMORY})
        else $error("memory written by an accumulator rotate");

    // Reset clears every output at the next edge, whatever was requested
    a_reset_clear: assert property (disable iff (1'b0)
        srst |=> !done_q && !acc_we_q && !mem_we_q && carry_q == `BRU_CARRY_RST
        && result_q == `BRU_RESULT_RST)
        else $error("outputs not cleared by reset");

    // Main scenarios: left and right carry rotates to memory, a memory rotate, streaming
    c_left_carry: cover property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY);
    c_right_carry: cover property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY);
    c_right_mem: cover property (
        req.valid && req.op == bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY);
    // Requests held high for consecutive cycles
    c_back_to_back: cover property (req.valid ##1 req.valid);
    // Accumulator write that leaves carry set
    c_acc_dest: cover property (acc_we_q && carry_q);
endmodule : bru_byte_rotate_unit

// >>> tb/bru_testbench.sv
// Self-checking testbench for the byte rotate unit
`timescale 1ns/100ps
module testbench;
    // Clock, reset and request
    logic              mclk = 1'b0;
    logic              srst = 1'b1;
    bru_pkg::bru_req_t req  = '0;
    // Registered outcome
    logic              done_q;
    logic [7:0]        result_q;
    logic              acc_we_q;
    logic              mem_we_q;
    logic              carry_q;
    // Counters; byte that must hold while idle
    int                err_count = 0;
    int                n_checks  = 0;
    logic [7:0]        last_q    = 8'h00;

    // Clock at 4 ns period
    always #2 mclk = ~mclk;

    bru_byte_rotate_unit dut (.mclk(mclk), .srst(srst), .req(req), .done_q(done_q),
        .result_q(result_q), .acc_we_q(acc_we_q), .mem_we_q(mem_we_q), .carry_q(carry_q));

    // Expected {byte, to_acc, carry}, built bit by bit
    function automatic logic [9:0] expect_of(bru_pkg::bru_op_t op, logic [7:0] m, logic c);
        case (op)
            bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR:       return {m[6:0], m[7], 1'b1, c};
            bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY:        return {m[6:0], c, 1'b0, m[7]};
            bru_pkg::BRU_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: return {m[6:0], c, 1'b1, m[7]};
            bru_pkg::BRU_OP_ROTATE_RIGHT_IN_MEMORY:           return {m[0], m[7:1], 1'b0, c};
            bru_pkg::BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR:      return {m[0], m[7:1], 1'b1, c};
            bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY:       return {c, m[7:1], 1'b0, m[0]};
            bru_pkg::BRU_OP_ROTATE_LEFT_IN_MEMORY:            return {m[6:0], m[7], 1'b0, c};
            default:                                          return {c, m[7:1], 1'b1, m[0]};
        endcase
    endfunction : expect_of

    // Byte compare
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte

    // Single bit compare
    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    // Issue one rotate at a falling edge, judge it one cycle later; valid stays up
    task automatic do_op(input bru_pkg::bru_op_t op, input logic [7:0] m, input logic c);
        logic [9:0] e;
        e = expect_of(op, m, c);
        req <= '{valid: 1'b1, op: op, mem: m, carry: c};
        @(negedge mclk);
        cmp_bit(done_q, 1'b1);
        cmp_byte(result_q, e[9:2]);
        cmp_bit(acc_we_q, e[1]);
        cmp_bit(mem_we_q, ~e[1]);
        cmp_bit(carry_q, e[0]);
        last_q = e[9:2];
    endtask : do_op

    // One idle cycle: no strobes, byte held, carry follows the supplied flag
    task automatic idle(input logic c);
        req <= '{valid: 1'b0, op: bru_pkg::BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR,
                 mem: 8'ha5, carry: c};
        @(negedge mclk);
        cmp_bit(done_q | acc_we_q | mem_we_q, 1'b0);
        cmp_byte(result_q, last_q);
        cmp_bit(carry_q, c);
    endtask : idle

    // Outputs are cleared by reset
    task automatic t_reset;
        cmp_byte(result_q, 8'h00);
        cmp_bit(done_q | acc_we_q | mem_we_q | carry_q, 1'b0);
        $display("test reset done");
    endtask : t_reset

    // Nine-bit left rotate with both end bits set
    task automatic t_walk;
        do_op(bru_pkg::BRU_OP_ROTATE_LEFT_THROUGH_CARRY, 8'h81, 1'b0);
        idle(1'b1);
        $display("test walk done");
    endtask : t_walk

    // Every code, both carries, wrap and mid patterns, back to back
    task automatic t_all_ops;
        bru_pkg::bru_op_t op_k;
        logic [7:0]       m_k;
        for (int k = 0; k < 32; k++) begin
            op_k = bru_pkg::bru_op_t'(k[2:0]);
            m_k  = k[4] ? 8'h81 : 8'h3c;
            do_op(op_k, m_k, k[3]);
        end
        idle(1'b0);
        $display("test all ops done");
    endtask : t_all_ops

    // Reset wins over a request in the same cycle; next edge accepts work
    task automatic t_mid_reset;
        req <= '{valid: 1'b1, op: bru_pkg::BRU_OP_ROTATE_RIGHT_THROUGH_CARRY,
                 mem: 8'h01, carry: 1'b1};
        srst <= 1'b1;
        @(negedge mclk);
        cmp_byte(result_q, 8'h00);
        cmp_bit(done_q | acc_we_q | mem_we_q | carry_q, 1'b0);
        srst <= 1'b0;
        do_op(bru_pkg::BRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 8'h01, 1'b1);
        idle(1'b0);
        $display("test mid reset done");
    endtask : t_mid_reset

    // Verdict and end of run
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence; every wait is a fixed cycle count
    initial begin
        repeat (4) @(negedge mclk);
        srst <= 1'b0;
        t_reset();
        t_walk();
        t_all_ops();
        t_mid_reset();
        finish_test();
    end
endmodule : testbench
